// ### spm_pkg.sv
// Constants shared by the serial port mode and status block.
// Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
package spm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] MODE_OFF    = 8'h04;
    localparam logic [7:0] IEN_SET_OFF = 8'h08;
    localparam logic [7:0] IEN_CLR_OFF = 8'h0c;
    localparam logic [7:0] IEN_STA_OFF = 8'h10;
    localparam logic [7:0] FLAGS_OFF   = 8'h14;
    localparam logic [7:0] RXHOLD_OFF  = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and mode register write mask.
    localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
    localparam logic [9:0]  MASK_RESET  = 10'h000;
    localparam logic [9:0]  FLAGS_RESET = 10'h018;
    localparam logic [31:0] MODE_WMASK  = 32'h0006_fff0;

    ////////////////////////////////////////////////////////////////////////////
    // Status, enable and mask bit positions.
    localparam int NFLAGS        = 10;
    localparam int RX_READY_BIT  = 0;
    localparam int TX_FREE_BIT   = 1;
    localparam int BREAK_BIT     = 2;
    localparam int RX_DONE_BIT   = 3;
    localparam int TX_DONE_BIT   = 4;
    localparam int OVERRUN_BIT   = 5;
    localparam int FRAMING_BIT   = 6;
    localparam int PARITY_BIT    = 7;
    localparam int TIMEOUT_BIT   = 8;
    localparam int TX_EMPTY_BIT  = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Control register command bits.
    localparam int CTRL_RXEN_BIT  = 4;
    localparam int CTRL_RXDIS_BIT = 5;
    localparam int CTRL_TXEN_BIT  = 6;
    localparam int CTRL_TXDIS_BIT = 7;
    localparam int CTRL_RSTSTA_BIT = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Mode register fields.
    localparam int CLKSRC_LSB = 4;
    localparam int CHAR_LEN_LSB  = 6;
    localparam int SYNC_BIT      = 8;
    localparam int STOP_CODE_LSB = 12;
    localparam int LOOP_MODE_LSB = 14;
    localparam int NINE_BIT_SEL  = 17;
    localparam int CLK_OUT_BIT   = 18;

    typedef enum logic [1:0] {
        SPM_NORMAL      = 2'b00,
        SPM_AUTO_ECHO   = 2'b01,
        SPM_LOCAL_LOOP  = 2'b10,
        SPM_REMOTE_LOOP = 2'b11
    } spm_loop_mode_type;

    // Stop length is given in half bit periods.
    localparam logic [2:0] STOP_HALF_1   = 3'h2;
    localparam logic [2:0] STOP_HALF_1_5 = 3'h3;
    localparam logic [2:0] STOP_HALF_2   = 3'h4;
    localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
    localparam logic [3:0] CHAR_BITS_9   = 4'h9;

endpackage

// ### spm_cfg_if.sv
// Configuration carrier between the register file and its helpers.
// Assumes the driver is the top module of the serial port mode block.
interface spm_cfg_if;
    logic [1:0] channel_loop_mode;
    logic       rx_enabled;
    logic       tx_enabled;
    logic       rx_read;
    logic       status_clear;

    modport ctrl (
        output channel_loop_mode,
        output rx_enabled,
        output tx_enabled,
        output rx_read,
        output status_clear
    );
    modport user (
        input  channel_loop_mode,
        input  rx_enabled,
        input  tx_enabled,
        input  rx_read,
        input  status_clear
    );
endinterface

// ### spm_line_mux.sv
// Serial line routing for the four channel modes.
// Assumes pin and transmitter levels are synchronous to hclk.
module spm_line_mux
    import spm_pkg::*;
(
    // Configuration.
    spm_cfg_if.user cfg,
    // Line levels.
    input  wire logic tx_serial,
    input  wire logic rxd_pin,
    output logic      txd_pin,
    output logic      rx_serial
);
    always_comb begin
        case (spm_loop_mode_type'(cfg.channel_loop_mode))
            SPM_NORMAL: begin
                txd_pin   = tx_serial;
                rx_serial = rxd_pin;
            end
            SPM_AUTO_ECHO: begin
                txd_pin   = rxd_pin;
                rx_serial = rxd_pin;
            end
            SPM_LOCAL_LOOP: begin
                txd_pin   = 1'b1;
                rx_serial = tx_serial;
            end
            SPM_REMOTE_LOOP: begin
                txd_pin   = rxd_pin;
                rx_serial = 1'b1;
            end
            default: begin
                txd_pin   = 1'b1;
                rx_serial = 1'b1;
            end
        endcase
    end
endmodule

// ### spm_rx_hold.sv
// Receive holding register with its ready and overrun flags.
// Assumes the receiver gives a one-cycle strobe per completed character.
module spm_rx_hold
    import spm_pkg::*;
(
    // Clock and reset.
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Configuration.
    spm_cfg_if.user         cfg,
    // Received characters.
    input  wire logic       rx_char_valid,
    input  wire logic [8:0] rx_char_data,
    // State.
    output logic [8:0]      rx_hold_data,
    output logic            rx_char_ready,
    output logic            rx_overrun_err
);
    logic rx_take;

    assign rx_take = rx_char_valid & cfg.rx_enabled;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_hold_data <= 9'h000;
        end else if (rx_take) begin
            rx_hold_data <= rx_char_data;
        end
    end

    // A new character wins over a read in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_char_ready <= 1'b0;
        end else if (!cfg.rx_enabled) begin
            rx_char_ready <= 1'b0;
        end else if (rx_take) begin
            rx_char_ready <= 1'b1;
        end else if (cfg.rx_read) begin
            rx_char_ready <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_overrun_err <= 1'b0;
        end else if (rx_take && rx_char_ready && !cfg.rx_read) begin
            rx_overrun_err <= 1'b1;
        end else if (cfg.status_clear) begin
            rx_overrun_err <= 1'b0;
        end
    end
endmodule

// ### spm_top.sv
// Mode, interrupt mask and channel status registers of a serial channel.
// Assumes one AHB-Lite master, hclk at 100 MHz and external baud logic.
////////////////////////////////////////////////////////////////////////////////
// Function
// - Stop code 00 one bit, 01 one and a half async, 10 two, 11 reserved.
// - Channel mode 00 runs receiver and transmitter normally on the pins.
// - Channel mode 01 echoes the receive pin onto the transmit pin.
// - Channel mode 10 feeds transmitter output to receiver, ignoring receive pin.
// - Channel mode 11 connects the receive pin straight to the transmit pin.
// - Nine-bit setting forces nine data bits, else length field decides.
// - Clock pin driven only when clock-out set and source upper bit is 0.
// - Enable-set write sets mask bits written as one.
// - Enable-clear write clears mask bits written as one.
// - Mask register is read only, resets to zero, shows enabled sources.
// - Enable, clear, mask and status share one ten-bit layout.
// - Status register is read only and resets to 0x18.
// - Receive-ready sets once a character arrives and is unread.
// - Receive-ready clears on holding read and reads zero when receiver off.
// - Interrupt line asserts when any status bit and its mask bit are set.
// - Sync-select bit picks asynchronous or synchronous stop interpretation.
// - Local loopback holds the transmit pin high.
// - Remote loopback disables transmitter and receiver.
//
// The AHB-Lite register port was left to the implementer.
module spm_top
    import spm_pkg::*;
(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins.
    input  wire logic        rxd_pin,
    output logic             txd_pin,
    output logic             sck_o,
    output logic             sck_oe,
    // Transmitter and receiver side.
    input  wire logic        tx_serial,
    output logic             rx_serial,
    input  wire logic        rx_char_valid,
    input  wire logic [8:0]  rx_char_data,
    input  wire logic        baud_clk_level,
    output logic             rx_active,
    output logic             tx_active,
    output logic [3:0]       char_bits,
    output logic [2:0]       stop_halves,
    output logic             sync_mode,
    // Event sources owned by the rest of the channel.
    input  wire logic        tx_holding_free,
    input  wire logic        rx_break_seen,
    input  wire logic        rx_transfer_done,
    input  wire logic        tx_transfer_done,
    input  wire logic        framing_err,
    input  wire logic        parity_err,
    input  wire logic        rx_timeout,
    input  wire logic        tx_all_drained,
    // Interrupt.
    output logic             irq
);
    import spm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus capture.
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic        ap_take;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [31:0] line_format_config;
    logic [9:0]  irq_enable_state;
    logic [9:0]  channel_flags;
    logic [9:0]  ext_flags;
    logic        rx_en_cmd;
    logic        tx_en_cmd;
    logic [8:0]  rx_hold_data;
    logic        rx_char_ready;
    logic        rx_overrun_err;
    logic [1:0]  loop_mode;
    logic [1:0]  clk_src;

    spm_cfg_if cfg ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign ap_take   = hsel & htrans[1] & hready;
    assign wr_strobe = dp_valid & dp_write;
    assign rd_strobe = dp_valid & ~dp_write;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_valid <= ap_take;
            if (ap_take) begin
                dp_write <= hwrite;
                dp_addr  <= {haddr[7:2], 2'b00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register and channel enables.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_format_config <= MODE_RESET;
        end else if (wr_strobe && hit(dp_addr, MODE_OFF)) begin
            line_format_config <= hwdata & MODE_WMASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_en_cmd <= 1'b0;
            tx_en_cmd <= 1'b0;
        end else if (wr_strobe && hit(dp_addr, CTRL_OFF)) begin
            if (hwdata[CTRL_RXDIS_BIT]) begin
                rx_en_cmd <= 1'b0;
            end else if (hwdata[CTRL_RXEN_BIT]) begin
                rx_en_cmd <= 1'b1;
            end
            if (hwdata[CTRL_TXDIS_BIT]) begin
                tx_en_cmd <= 1'b0;
            end else if (hwdata[CTRL_TXEN_BIT]) begin
                tx_en_cmd <= 1'b1;
            end
        end
    end

    assign loop_mode = line_format_config[LOOP_MODE_LSB +: 2];
    assign clk_src   = line_format_config[CLKSRC_LSB +: 2];

    assign cfg.channel_loop_mode = loop_mode;
    assign cfg.rx_enabled   = rx_en_cmd & (loop_mode != SPM_REMOTE_LOOP);
    assign cfg.tx_enabled   = tx_en_cmd & (loop_mode != SPM_REMOTE_LOOP);
    assign cfg.rx_read      = rd_strobe & hit(dp_addr, RXHOLD_OFF);
    assign cfg.status_clear = wr_strobe & hit(dp_addr, CTRL_OFF) & hwdata[CTRL_RSTSTA_BIT];

    assign rx_active = cfg.rx_enabled;
    assign tx_active = cfg.tx_enabled;

    ////////////////////////////////////////////////////////////////////////////
    // Line format decode.
    assign sync_mode = line_format_config[SYNC_BIT];

    always_comb begin
        case (line_format_config[STOP_CODE_LSB +: 2])
            2'b00:   stop_halves = STOP_HALF_1;
            2'b01:   stop_halves = sync_mode ? STOP_HALF_1 : STOP_HALF_1_5;
            2'b10:   stop_halves = STOP_HALF_2;
            default: stop_halves = STOP_HALF_1;
        endcase
    end

    always_comb begin
        if (line_format_config[NINE_BIT_SEL]) begin
            char_bits = CHAR_BITS_9;
        end else begin
            char_bits = CHAR_BITS_MIN + {2'b00, line_format_config[CHAR_LEN_LSB +: 2]};
        end
    end

    assign sck_oe = line_format_config[CLK_OUT_BIT] & ~clk_src[1];
    assign sck_o  = baud_clk_level;

    ////////////////////////////////////////////////////////////////////////////
    // Line routing and receive holding.
    spm_line_mux u_line (
        .cfg       (cfg.user),
        .tx_serial (tx_serial),
        .rxd_pin   (rxd_pin),
        .txd_pin   (txd_pin),
        .rx_serial (rx_serial)
    );

    spm_rx_hold u_hold (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .cfg            (cfg.user),
        .rx_char_valid  (rx_char_valid),
        .rx_char_data   (rx_char_data),
        .rx_hold_data   (rx_hold_data),
        .rx_char_ready  (rx_char_ready),
        .rx_overrun_err (rx_overrun_err)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt mask and channel status.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable_state <= MASK_RESET;
        end else if (wr_strobe && hit(dp_addr, IEN_SET_OFF)) begin
            irq_enable_state <= irq_enable_state | hwdata[NFLAGS-1:0];
        end else if (wr_strobe && hit(dp_addr, IEN_CLR_OFF)) begin
            irq_enable_state <= irq_enable_state & ~hwdata[NFLAGS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_flags <= FLAGS_RESET;
        end else begin
            ext_flags <= {tx_all_drained, rx_timeout, parity_err, framing_err, 1'b0,
                          tx_transfer_done, rx_transfer_done, rx_break_seen, tx_holding_free, 1'b0};
        end
    end

    always_comb begin
        channel_flags               = ext_flags;
        // Masked by the enable so the flag reads zero in the very cycle the receiver stops.
        channel_flags[RX_READY_BIT] = rx_char_ready & cfg.rx_enabled;
        channel_flags[OVERRUN_BIT]  = rx_overrun_err;
    end

    assign irq = |(channel_flags & irq_enable_state);

    ////////////////////////////////////////////////////////////////////////////
    // Read data.
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_strobe) begin
            case (dp_addr)
                MODE_OFF:    hrdata = line_format_config;
                IEN_STA_OFF: hrdata = {22'h000000, irq_enable_state};
                FLAGS_OFF:   hrdata = {22'h000000, channel_flags};
                RXHOLD_OFF:  hrdata = {23'h000000, rx_hold_data};
                default:     hrdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    mask_set_a: assert property (wr_strobe && hit(dp_addr, IEN_SET_OFF)
        |=> (irq_enable_state & $past(hwdata[9:0])) == $past(hwdata[9:0])
            && (irq_enable_state & $past(irq_enable_state)) == $past(irq_enable_state))
        else $error("Enable-set write did not set the mask bits.");

    mask_clear_a: assert property (wr_strobe && hit(dp_addr, IEN_CLR_OFF)
        |=> (irq_enable_state & $past(hwdata[9:0])) == 10'h000
            && irq_enable_state == ($past(irq_enable_state) & ~$past(hwdata[9:0])))
        else $error("Enable-clear write did not clear the mask bits.");

    irq_line_a: assert property (irq == ((channel_flags & irq_enable_state) != 10'h000))
        else $error("Interrupt line disagrees with status and mask.");

    rx_ready_set_a: assert property (rx_char_valid && cfg.rx_enabled ##1 cfg.rx_enabled
        |-> channel_flags[RX_READY_BIT])
        else $error("Receive-ready did not set after a character.");

    rx_ready_read_a: assert property (cfg.rx_read && !rx_char_valid
        |=> !channel_flags[RX_READY_BIT])
        else $error("Receive-ready did not clear after a holding read.");

    rx_off_zero_a: assert property (!cfg.rx_enabled |=> !rx_char_ready)
        else $error("Receive-ready set while receiver disabled.");

    local_loop_a: assert property (loop_mode == SPM_LOCAL_LOOP
        |-> txd_pin && rx_serial == tx_serial)
        else $error("Local loopback routing wrong.");

    remote_loop_a: assert property (loop_mode == SPM_REMOTE_LOOP
        |-> txd_pin == rxd_pin && !rx_active && !tx_active)
        else $error("Remote loopback routing wrong.");

    echo_path_a: assert property (loop_mode == SPM_AUTO_ECHO |-> txd_pin == rxd_pin)
        else $error("Echo path does not follow the receive pin.");

    clock_drive_a: assert property (sck_oe |-> line_format_config[CLK_OUT_BIT] && !clk_src[1])
        else $error("Clock pin driven against its setting.");

    nine_bit_a: assert property (line_format_config[NINE_BIT_SEL] |-> char_bits == 4'h9)
        else $error("Nine-bit setting not honoured.");

    upper_zero_a: assert property (rd_strobe && (hit(dp_addr, FLAGS_OFF) || hit(dp_addr, IEN_STA_OFF))
        |-> hrdata[31:10] == 22'h000000)
        else $error("Undefined status bits read non-zero.");

    cover_rx_read_c: cover property (rx_char_ready ##[1:20] cfg.rx_read);
    cover_irq_c: cover property (!irq ##1 irq);
    cover_local_c: cover property (loop_mode == SPM_LOCAL_LOOP && rx_char_valid);
    cover_overrun_c: cover property (rx_overrun_err);
endmodule

// ### spm_far_end.sv
// Remote serial device facing the transmit and receive pins.
// Assumes the bench picks the level sent and reads what was heard.
module spm_far_end (
    // Clock.
    input  wire logic hclk,
    // Line levels.
    input  wire logic send_bit,
    input  wire logic txd_pin,
    output logic      rxd_pin,
    output logic      heard
);
    timeunit 1ns;
    timeprecision 1ps;

    assign rxd_pin = send_bit;

    // The level on the transmit pin is latched once per clock.
    always_ff @(posedge hclk) begin
        heard <= txd_pin;
    end
endmodule

// ### spm_top_tb.sv
// Self-checking bench for the serial port mode and status block.
// Assumes hready is looped back from hreadyout and one bus master.
module spm_top_tb;
    import spm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk           = 1'b0;
    logic        hresetn        = 1'b0;
    logic        hsel           = 1'b0;
    logic        hwrite         = 1'b0;
    logic [7:0]  haddr          = 8'h00;
    logic [1:0]  htrans         = 2'h0;
    logic [31:0] hwdata         = 32'h0;
    logic [7:0]  ev             = 8'h0c;
    logic        tx_serial      = 1'b1;
    logic        send_bit       = 1'b1;
    logic        rx_char_valid  = 1'b0;
    logic [8:0]  rx_char_data   = 9'h000;
    logic        baud_clk_level = 1'b0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, rxd_pin, txd_pin, sck_o, sck_oe, heard;
    logic        rx_serial, rx_active, tx_active, sync_mode, irq;
    logic [3:0]  char_bits;
    logic [2:0]  stop_halves;
    int          error_cnt = 0;
    int          n_checks  = 0;

    always #5 hclk = ~hclk;

    spm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .sck_o(sck_o),
        .sck_oe(sck_oe), .tx_serial(tx_serial), .rx_serial(rx_serial), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .baud_clk_level(baud_clk_level), .rx_active(rx_active),
        .tx_active(tx_active), .char_bits(char_bits), .stop_halves(stop_halves), .sync_mode(sync_mode),
        .tx_holding_free(ev[0]), .rx_break_seen(ev[1]), .rx_transfer_done(ev[2]),
        .tx_transfer_done(ev[3]), .framing_err(ev[4]), .parity_err(ev[5]), .rx_timeout(ev[6]),
        .tx_all_drained(ev[7]), .irq(irq));

    spm_far_end far (.hclk(hclk), .send_bit(send_bit), .txd_pin(txd_pin), .rxd_pin(rxd_pin), .heard(heard));

    ////////////////////////////////////////////////////////////
    task give_verdict;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for an edge with hready high; a stuck bus ends the run.
    task edge_rdy;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        edge_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(hresp), 32'h0);
    endtask

    task char_in(input logic [8:0] d);
        @(posedge hclk);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        @(posedge hclk);
        rx_char_valid <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////
    task t_reset;
        rd_chk(IEN_STA_OFF, 32'h0);
        rd_chk(FLAGS_OFF, 32'h18);
        xfer(1'b1, 8'h3c, 32'hffff_ffff);
        rd_chk(8'h3c, 32'h0);
        xfer(1'b1, MODE_OFF, 32'hffff_cfff);
        rd_chk(MODE_OFF, MODE_WMASK & 32'hffff_cfff);
        xfer(1'b1, MODE_OFF, 32'h0);
    endtask

    task t_mask;
        xfer(1'b1, IEN_SET_OFF, 32'hffff_ffff);
        rd_chk(IEN_STA_OFF, 32'h3ff);
        chk(32'(irq), 32'h1);
        xfer(1'b1, IEN_CLR_OFF, 32'h155);
        rd_chk(IEN_STA_OFF, 32'h2aa);
        xfer(1'b1, IEN_CLR_OFF, 32'hffff_fc00);
        xfer(1'b1, IEN_SET_OFF, 32'h0);
        rd_chk(IEN_STA_OFF, 32'h2aa);
        xfer(1'b1, IEN_CLR_OFF, 32'h3ff);
        rd_chk(IEN_STA_OFF, 32'h0);
        chk(32'(irq), 32'h0);
    endtask

    task t_events;
        ev <= 8'hff;
        rd_chk(FLAGS_OFF, 32'h3de);
        ev <= 8'h0c;
        rd_chk(FLAGS_OFF, 32'h18);
    endtask

    task t_rx;
        xfer(1'b1, CTRL_OFF, 32'h10);
        char_in(9'h1a5);
        rd_chk(FLAGS_OFF, 32'h19);
        xfer(1'b1, IEN_SET_OFF, 32'h1);
        @(negedge hclk);
        chk(32'(irq), 32'h1);
        rd_chk(RXHOLD_OFF, 32'h1a5);
        rd_chk(FLAGS_OFF, 32'h18);
        chk(32'(irq), 32'h0);
        char_in(9'h0f0);
        xfer(1'b1, CTRL_OFF, 32'h20);
        rd_chk(FLAGS_OFF, 32'h18);
        xfer(1'b1, IEN_CLR_OFF, 32'h1);
    endtask

    // Every length, sync and clock-out code; reserved stop codes are never written.
    task t_fmt;
        logic [31:0] w;
        logic [3:0]  b;
        logic [1:0]  s;
        for (int i = 0; i < 16; i++) begin
            b = 4'(i);
            s = {b[1], b[0] & ~b[1] & ~b[2]};
            w = 32'h0;
            w[CLKSRC_LSB+:2] = {b[3], b[0]};
            w[CHAR_LEN_LSB+:2] = b[1:0];
            w[SYNC_BIT] = b[2];
            w[STOP_CODE_LSB+:2] = s;
            w[NINE_BIT_SEL] = b[3];
            w[CLK_OUT_BIT] = b[2];
            xfer(1'b1, MODE_OFF, w);
            baud_clk_level <= b[0];
            @(negedge hclk);
            chk(32'(stop_halves), 32'((s == 2'd2) ? STOP_HALF_2 :
                (s == 2'd1) ? STOP_HALF_1_5 : STOP_HALF_1));
            chk(32'(sck_o), 32'(b[0]));
            chk(32'(sync_mode), 32'(b[2]));
            chk(32'(char_bits), 32'(b[3] ? CHAR_BITS_9 : CHAR_BITS_MIN + 4'(b[1:0])));
            chk(32'(sck_oe), 32'(b[2] & ~b[3]));
        end
    endtask

    task t_chan;
        logic [31:0] w;
        logic [31:0] e;
        xfer(1'b1, CTRL_OFF, 32'h50);
        for (int m = 0; m < 4; m++) begin
            w = 32'h0;
            w[LOOP_MODE_LSB+:2] = 2'(m);
            xfer(1'b1, MODE_OFF, w);
            for (int p = 0; p < 2; p++) begin
                @(posedge hclk);
                send_bit <= 1'(p);
                tx_serial <= ~1'(p);
                @(negedge hclk);
                e = (m == 0) ? 32'(p ^ 1) : (m == 2) ? 32'h1 : 32'(p);
                chk(32'(txd_pin), e);
                chk(32'(rx_serial), (m == 2) ? 32'(p ^ 1) : (m == 3) ? 32'h1 : 32'(p));
                chk(32'({rx_active, tx_active}), (m == 3) ? 32'h0 : 32'h3);
                @(negedge hclk);
                chk(32'(heard), e);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_mask();
        t_events();
        t_rx();
        t_fmt();
        t_chan();
        give_verdict();
    end
endmodule
